// ===== rtl/motion_decl_pkg.sv
// Purpose: Shared constants and types for the motion declaration block
// Assumes: Two tasks, four axes, APB register access
// Notes: Offsets in micrometres, angles in tenths of a degree
package motion_decl_pkg;
  localparam int NT = 2;
  localparam int NA = 4;
  localparam int PW = 24;
  localparam logic [4:0] R_SIG = 5'h00;
  localparam logic [4:0] R_ARC = 5'h01;
  localparam logic [4:0] R_BASE = 5'h02;
  localparam logic [4:0] R_GRP = 5'h03;
  localparam logic [4:0] R_OFS = 5'h04;
  localparam logic [4:0] R_HOLD = 5'h05;
  localparam logic [4:0] R_ABRT = 5'h06;
  localparam logic [4:0] R_CTRL = 5'h07;
  localparam logic [4:0] R_STAT = 5'h08;
  localparam logic [4:0] R_OFSRD = 5'h0c;
  localparam int TASK_BIT = 7;
  localparam int OFS_PAT_LSB = 24;
  localparam int DECL_SRC_LSB = 8;
  localparam int DECL_TYP_LSB = 16;
  localparam int DECL_TYP_GIVEN = 18;
  localparam logic [5:0] SIG_MAX = 6'h32;
  localparam logic [10:0] ARC_MAX = 11'h4b0;
  localparam logic [10:0] ARC_AUTO_MAX = 11'h708;
  localparam logic [10:0] ARC_DEF = 11'h064;
  typedef enum logic [1:0] {HT_NO = 2'b00, HT_NC = 2'b01, HT_NC_OFF = 2'b10} hold_type_t;
  typedef enum logic [1:0] {PS_RUN = 2'b00, PS_HELD = 2'b01, PS_RETURN = 2'b10} pause_st_t;
  typedef struct packed {
    logic en;
    logic [4:0] src;
    logic [1:0] typ;
  } decl_t;
  typedef struct packed {
    logic [5:0] ratio;
    logic [10:0] arc;
    logic [1:0] base;
    logic [NA-1:0] axis_group_mask_cmd;
    logic [NA-1:0][PW-1:0] ofs;
    decl_t hold;
    decl_t abrt;
  } task_cfg_t;
  localparam task_cfg_t CFG_RST = '{ratio: 6'h00, arc: ARC_DEF, base: 2'h0, axis_group_mask_cmd: 4'hf,
                                    ofs: '0, hold: '0, abrt: '0};
  typedef struct packed {
    logic valid;
    logic tsk;
    logic home;
    logic [NA-1:0][PW-1:0] tgt;
  } move_in_t;
  typedef struct packed {
    logic valid;
    logic tsk;
    logic trap;
    logic [5:0] ratio;
    logic [10:0] arc;
    logic [NA-1:0] axes;
    logic [NA-1:0][PW-1:0] tgt;
  } move_out_t;
  typedef struct packed {
    task_cfg_t [NT-1:0] cfg;
    pause_st_t [NT-1:0] pst;
    logic [NT-1:0][NA-1:0] was_on;
    logic [NT-1:0][NA-1:0] offd;
    logic [NT-1:0] apend;
    logic [15:0] din1;
    logic [15:0] din2;
    logic dup;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    move_out_t mv;
    logic [NT-1:0] pause;
    logic [NT-1:0] abrt;
    logic [NT-1:0] adone;
    logic [NT-1:0] retq;
    logic [NT-1:0] resume;
    logic [NT-1:0] hrst;
    logic [NA-1:0] svoff;
    logic [NA-1:0] restore;
  } st_t;
  localparam st_t ST_RST = '{cfg: {NT{CFG_RST}}, default: '0};
endpackage

// ===== rtl/motion_decl.sv
// Purpose: Per-task motion declarations, move transform, pause and abort control
// Assumes: APB slave, one access cycle; axis status inputs on pclk
// Notes: Source index bit 4 picks a global flag, else a pin
// Summary of operation
// RULE_01 Sigmoid ratio accepted only as integer 0 to 50 percent.
// RULE_02 Ratio zero or never declared gives a trapezoid profile.
// RULE_03 Offset of each pattern-selected axis is added to its target.
// RULE_04 Offsets held in 0.001 mm units, negative values allowed.
// RULE_05 Offset and group mask act on logical axes before base shift.
// RULE_06 Division angle accepted 0 to 120 degrees in tenths.
// RULE_07 Angle zero uses a computed angle, never above 180 degrees.
// RULE_08 Base renumbers axes so the given axis counts as first.
// RULE_09 Group mask keeps only selected axes' data valid.
// RULE_10 Axis pattern is a bit mask, bit n selects axis n+1.
// RULE_11 Active pause input halts servo work with deceleration stop.
// RULE_12 Empty source operand invalidates the pause or abort declaration.
// RULE_13 Pause type 0 open, 1 closed, 2 closed then servo off.
// RULE_14 Pause type resets to 0 at start; empty type keeps it.
// RULE_15 Servo-on from another task to a held-off axis flags error.
// RULE_16 Release of servo-off pause turns back on previously-on axes.
// RULE_17 Displaced held axis returns to stop point before resuming.
// RULE_18 Pause and abort act only on the declaring task's axes.
// RULE_19 Pause and abort act on all servo commands except servo off.
// RULE_20 Paused home return restarts from the sequence beginning.
// RULE_21 Active abort input decelerates to stop then aborts.
// RULE_22 Abort type 0 open, 1 closed; resets to 0; empty keeps.
// RULE_23 Open contact active when on, closed contact active when off.
// RULE_24 Each task keeps its own independent declaration copy.
`timescale 1ns/100ps
module motion_decl
  import motion_decl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] din,
  input wire logic [15:0] gflag,
  input wire logic [motion_decl_pkg::NT-1:0] cmd_active,
  input wire logic [motion_decl_pkg::NT-1:0] cmd_svoff,
  input wire logic [motion_decl_pkg::NT-1:0] cmd_home,
  input wire logic [motion_decl_pkg::NA-1:0] axis_servo_on,
  input wire logic [motion_decl_pkg::NA-1:0] axis_moving,
  input wire logic [motion_decl_pkg::NA-1:0] axis_displaced,
  input wire logic [motion_decl_pkg::NT-1:0] return_done,
  input wire logic son_req,
  input wire logic son_tsk,
  input wire logic [motion_decl_pkg::NA-1:0] son_axes,
  input wire motion_decl_pkg::move_in_t move_in,
  input wire logic [10:0] auto_arc,
  output motion_decl_pkg::move_out_t move_out,
  output logic [motion_decl_pkg::NT-1:0] pause_req,
  output logic [motion_decl_pkg::NT-1:0] abort_req,
  output logic [motion_decl_pkg::NT-1:0] abort_done,
  output logic [motion_decl_pkg::NT-1:0] return_req,
  output logic [motion_decl_pkg::NT-1:0] resume,
  output logic [motion_decl_pkg::NT-1:0] home_restart,
  output logic [motion_decl_pkg::NA-1:0] servo_off_req,
  output logic [motion_decl_pkg::NA-1:0] servo_restore,
  output logic dup_err
);
  import motion_decl_pkg::*;

  st_t s_q;
  st_t s_d;
  logic [NT-1:0] hold_on;
  logic [NT-1:0] abort_on;
  logic [NT-1:0][NA-1:0] task_axes;

  always_comb begin
    logic acc;
    logic t;
    logic [4:0] ra;
    logic lvl;
    logic err;
    logic [31:0] rd;
    logic [PW-1:0] sum;
    logic stopped_ok;
    int j;
    acc = psel & penable & s_q.pready;
    t = paddr[TASK_BIT];
    ra = paddr[6:2];
    lvl = 1'b0;
    err = 1'b0;
    rd = '0;
    sum = '0;
    stopped_ok = 1'b0;
    j = 0;
    s_d = s_q;
    s_d.din1 = din;
    s_d.din2 = s_q.din1;
    s_d.pready = psel & ~penable;
    s_d.adone = '0;
    s_d.resume = '0;
    s_d.hrst = '0;
    s_d.restore = '0;
    s_d.mv.valid = 1'b0;
    hold_on = '0;
    abort_on = '0;
    for (int k = 0; k < NT; k++) begin
      task_axes[k] = s_q.cfg[k].axis_group_mask_cmd << s_q.cfg[k].base; // RULE_18
    end

    // Register decode, value checks in setup phase
    case (ra)
      R_SIG: begin
        rd = {26'h0, s_q.cfg[t].ratio};
        err = pwrite && (pwdata > 32'(SIG_MAX)); // RULE_01
      end
      R_ARC: begin
        rd = {21'h0, s_q.cfg[t].arc};
        err = pwrite && (pwdata > 32'(ARC_MAX)); // RULE_06
      end
      R_BASE: begin
        rd = 32'(s_q.cfg[t].base) + 32'h1;
        err = pwrite && (pwdata == 32'h0 || pwdata > 32'(NA));
      end
      R_GRP: rd = {28'h0, s_q.cfg[t].axis_group_mask_cmd};
      R_OFS: rd = '0;
      R_HOLD: begin
        rd = {14'h0, s_q.cfg[t].hold.typ, 3'h0, s_q.cfg[t].hold.src, 7'h0, s_q.cfg[t].hold.en};
        err = pwrite && pwdata[DECL_TYP_GIVEN] && (pwdata[DECL_TYP_LSB+:2] == 2'h3);
      end
      R_ABRT: begin
        rd = {14'h0, s_q.cfg[t].abrt.typ, 3'h0, s_q.cfg[t].abrt.src, 7'h0, s_q.cfg[t].abrt.en};
        err = pwrite && pwdata[DECL_TYP_GIVEN] && pwdata[DECL_TYP_LSB+1];
      end
      R_CTRL: rd = '0;
      R_STAT: rd = {24'h0, s_q.offd[t], s_q.dup, s_q.apend[t], s_q.pst[t]};
      default: begin
        if (ra >= R_OFSRD && ra < R_OFSRD + 5'(NA)) begin
          rd = 32'(signed'(s_q.cfg[t].ofs[ra[1:0]]));
          err = pwrite;
        end else begin
          err = 1'b1;
        end
      end
    endcase
    if (psel & ~penable) begin
      s_d.prdata = pwrite ? 32'h0 : rd;
      s_d.pslverr = err;
    end

    // Writes take effect at the access edge only
    if (acc && pwrite && !s_q.pslverr) begin
      case (ra)
        R_SIG: s_d.cfg[t].ratio = pwdata[5:0];
        R_ARC: s_d.cfg[t].arc = pwdata[10:0];
        R_BASE: s_d.cfg[t].base = 2'(pwdata[2:0] - 3'h1); // RULE_08
        R_GRP: s_d.cfg[t].axis_group_mask_cmd = pwdata[NA-1:0]; // RULE_09
        R_OFS: begin
          for (int i = 0; i < NA; i++) begin
            if (pwdata[OFS_PAT_LSB+i]) begin
              s_d.cfg[t].ofs[i] = pwdata[PW-1:0]; // RULE_10 RULE_04
            end
          end
        end
        R_HOLD: begin
          s_d.cfg[t].hold.en = pwdata[0]; // RULE_12
          s_d.cfg[t].hold.src = pwdata[DECL_SRC_LSB+:5];
          if (pwdata[DECL_TYP_GIVEN]) begin
            s_d.cfg[t].hold.typ = pwdata[DECL_TYP_LSB+:2]; // RULE_13 RULE_14
          end
        end
        R_ABRT: begin
          s_d.cfg[t].abrt.en = pwdata[0]; // RULE_12
          s_d.cfg[t].abrt.src = pwdata[DECL_SRC_LSB+:5];
          if (pwdata[DECL_TYP_GIVEN]) begin
            s_d.cfg[t].abrt.typ = pwdata[DECL_TYP_LSB+:2]; // RULE_22
          end
        end
        R_CTRL: begin
          if (pwdata[0]) begin
            s_d.cfg[t] = CFG_RST; // RULE_14 RULE_22 RULE_02
          end
          if (pwdata[1]) begin
            s_d.dup = 1'b0;
          end
        end
        default: s_d.dup = s_d.dup;
      endcase
    end

    // Axis duplication check, set wins over clear
    if (son_req && |(son_axes & s_q.offd[~son_tsk])) begin
      s_d.dup = 1'b1; // RULE_15
    end

    // Pause and abort per task
    for (int k = 0; k < NT; k++) begin
      lvl = s_q.cfg[k].hold.src[4] ? gflag[s_q.cfg[k].hold.src[3:0]] : s_q.din2[s_q.cfg[k].hold.src[3:0]];
      hold_on[k] = s_q.cfg[k].hold.en && cmd_active[k] && !cmd_svoff[k]
                   && (s_q.cfg[k].hold.typ == HT_NO ? lvl : !lvl); // RULE_19 RULE_23
      lvl = s_q.cfg[k].abrt.src[4] ? gflag[s_q.cfg[k].abrt.src[3:0]] : s_q.din2[s_q.cfg[k].abrt.src[3:0]];
      abort_on[k] = s_q.cfg[k].abrt.en && cmd_active[k] && !cmd_svoff[k]
                    && (s_q.cfg[k].abrt.typ[0] ? !lvl : lvl); // RULE_19 RULE_23
      stopped_ok = !(|(axis_moving & task_axes[k]));
      case (s_q.pst[k])
        PS_RUN: begin
          if (hold_on[k]) begin
            s_d.pst[k] = PS_HELD; // RULE_11
            s_d.was_on[k] = axis_servo_on & task_axes[k];
          end
        end
        PS_HELD: begin
          if (!hold_on[k]) begin
            s_d.restore = s_d.restore | (s_q.offd[k] & s_q.was_on[k]); // RULE_16
            s_d.offd[k] = '0;
            if (|(axis_displaced & s_q.offd[k] & s_q.was_on[k])) begin
              s_d.pst[k] = PS_RETURN; // RULE_17
            end else begin
              s_d.pst[k] = PS_RUN;
              s_d.resume[k] = 1'b1;
              s_d.hrst[k] = cmd_home[k]; // RULE_20
            end
          end else if (s_q.cfg[k].hold.typ == HT_NC_OFF && stopped_ok) begin
            s_d.offd[k] = task_axes[k]; // RULE_13
          end
        end
        PS_RETURN: begin
          if (return_done[k]) begin
            s_d.pst[k] = PS_RUN; // RULE_17
            s_d.resume[k] = 1'b1;
            s_d.hrst[k] = cmd_home[k]; // RULE_20
          end
        end
        default: s_d.pst[k] = PS_RUN;
      endcase
      s_d.pause[k] = (s_d.pst[k] == PS_HELD);
      s_d.retq[k] = (s_d.pst[k] == PS_RETURN);
      if (abort_on[k] && !s_q.apend[k]) begin
        s_d.apend[k] = 1'b1; // RULE_21
      end else if (s_q.apend[k] && stopped_ok) begin
        s_d.apend[k] = 1'b0;
        s_d.adone[k] = 1'b1; // RULE_21
      end
      s_d.abrt[k] = s_d.apend[k];
    end
    s_d.svoff = '0;
    for (int k = 0; k < NT; k++) begin
      s_d.svoff = s_d.svoff | s_d.offd[k];
    end

    // Move transform: offset and group on logical axes, then base shift
    if (move_in.valid) begin
      s_d.mv.valid = 1'b1;
      s_d.mv.tsk = move_in.tsk;
      s_d.mv.ratio = s_q.cfg[move_in.tsk].ratio;
      s_d.mv.trap = (s_q.cfg[move_in.tsk].ratio == 6'h00); // RULE_02
      if (s_q.cfg[move_in.tsk].arc != 11'h000) begin
        s_d.mv.arc = s_q.cfg[move_in.tsk].arc;
      end else if (auto_arc == 11'h000 || auto_arc > ARC_AUTO_MAX) begin
        s_d.mv.arc = ARC_AUTO_MAX; // RULE_07
      end else begin
        s_d.mv.arc = auto_arc; // RULE_07
      end
      s_d.mv.axes = '0;
      s_d.mv.tgt = '0;
      for (int i = 0; i < NA; i++) begin
        sum = move_in.tgt[i] + s_q.cfg[move_in.tsk].ofs[i]; // RULE_03
        j = i + int'(s_q.cfg[move_in.tsk].base); // RULE_05 RULE_08
        if (s_q.cfg[move_in.tsk].axis_group_mask_cmd[i] && j < NA) begin
          s_d.mv.axes[j] = 1'b1; // RULE_09
          s_d.mv.tgt[j] = sum;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= ST_RST; // RULE_24
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign move_out = s_q.mv;
  assign pause_req = s_q.pause;
  assign abort_req = s_q.abrt;
  assign abort_done = s_q.adone;
  assign return_req = s_q.retq;
  assign resume = s_q.resume;
  assign home_restart = s_q.hrst;
  assign servo_off_req = s_q.svoff;
  assign servo_restore = s_q.restore;
  assign dup_err = s_q.dup;

  property p_sig_range;
    @(posedge pclk) disable iff (!presetn) s_q.cfg[0].ratio <= SIG_MAX && s_q.cfg[1].ratio <= SIG_MAX;
  endproperty
  a_sig_range: assert property (p_sig_range) else $error("ratio out of range"); // RULE_01

  property p_trap;
    @(posedge pclk) disable iff (!presetn) move_in.valid && !move_in.tsk
      |=> move_out.trap == (move_out.ratio == 6'h00) && move_out.ratio == $past(s_q.cfg[0].ratio);
  endproperty
  a_trap: assert property (p_trap) else $error("profile kind wrong"); // RULE_02

  property p_ofs;
    @(posedge pclk) disable iff (!presetn)
      move_in.valid && !move_in.tsk && s_q.cfg[0].axis_group_mask_cmd[1] && s_q.cfg[0].base == 2'h0
      |=> move_out.axes[1] && move_out.tgt[1] == $past(move_in.tgt[1]) + $past(s_q.cfg[0].ofs[1]);
  endproperty
  a_ofs: assert property (p_ofs) else $error("offset not applied"); // RULE_03

  property p_arc;
    @(posedge pclk) disable iff (!presetn) move_out.valid |-> move_out.arc != 11'h000 && move_out.arc <= ARC_AUTO_MAX;
  endproperty
  a_arc: assert property (p_arc) else $error("division angle bad"); // RULE_07

  property p_hold;
    @(posedge pclk) disable iff (!presetn) hold_on[0] && s_q.pst[0] == PS_RUN |=> pause_req[0] [*1];
  endproperty
  a_hold: assert property (p_hold) else $error("pause not raised"); // RULE_11

  property p_svoff;
    @(posedge pclk) disable iff (!presetn) cmd_svoff[0] && s_q.pst[0] == PS_RUN && !s_q.apend[0]
      |=> !pause_req[0] && !abort_req[0];
  endproperty
  a_svoff: assert property (p_svoff) else $error("servo off command paused"); // RULE_19

  property p_abort;
    @(posedge pclk) disable iff (!presetn) abort_on[0] && !s_q.apend[0] |=> abort_req[0] ##[0:1000] 1'b1;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not raised"); // RULE_21

  property p_dup;
    @(posedge pclk) disable iff (!presetn) son_req && |(son_axes & s_q.offd[~son_tsk]) |=> dup_err;
  endproperty
  a_dup: assert property (p_dup) else $error("duplication not flagged"); // RULE_15

  property p_restore;
    @(posedge pclk) disable iff (!presetn) s_q.pst[0] == PS_HELD && !hold_on[0]
      |=> (servo_restore & $past(s_q.offd[0])) == ($past(s_q.offd[0]) & $past(s_q.was_on[0]));
  endproperty
  a_restore: assert property (p_restore) else $error("servo not restored"); // RULE_16

  property p_home;
    @(posedge pclk) disable iff (!presetn) s_q.pst[0] == PS_RETURN && return_done[0] && cmd_home[0]
      |=> home_restart[0] && resume[0];
  endproperty
  a_home: assert property (p_home) else $error("home not restarted"); // RULE_20

  property p_arc_range;
    @(posedge pclk) disable iff (!presetn) s_q.cfg[0].arc <= ARC_MAX && s_q.cfg[1].arc <= ARC_MAX;
  endproperty
  a_arc_range: assert property (p_arc_range) else $error("stored division angle out of range"); // RULE_06

  property p_invalid;
    @(posedge pclk) disable iff (!presetn) !s_q.cfg[0].hold.en && s_q.pst[0] == PS_RUN |=> !pause_req[0];
  endproperty
  a_invalid: assert property (p_invalid) else $error("pause from invalid declaration"); // RULE_12

  property p_offd;
    @(posedge pclk) disable iff (!presetn) s_q.pst[0] == PS_HELD && hold_on[0] && s_q.cfg[0].hold.typ == HT_NC_OFF
      && (axis_moving & task_axes[0]) == '0 |=> (servo_off_req & $past(task_axes[0])) == $past(task_axes[0]);
  endproperty
  a_offd: assert property (p_offd) else $error("servo off not requested"); // RULE_13

  property p_return;
    @(posedge pclk) disable iff (!presetn) s_q.pst[0] == PS_HELD && !hold_on[0]
      && |(axis_displaced & s_q.offd[0] & s_q.was_on[0]) |=> return_req[0] && !resume[0];
  endproperty
  a_return: assert property (p_return) else $error("return to stop point skipped"); // RULE_17

  property p_abrt_type;
    @(posedge pclk) disable iff (!presetn) s_q.cfg[0].abrt.typ <= 2'h1 && s_q.cfg[1].abrt.typ <= 2'h1;
  endproperty
  a_abrt_type: assert property (p_abrt_type) else $error("abort type out of range"); // RULE_22

  c_hold: cover property (@(posedge pclk) disable iff (!presetn) pause_req[0] ##1 resume[0]);
  c_abort: cover property (@(posedge pclk) disable iff (!presetn) abort_req[0] ##[1:20] abort_done[0]);
  c_return: cover property (@(posedge pclk) disable iff (!presetn) return_req[0] ##[1:20] resume[0]);
endmodule

// ===== tb/servo_axes_model.sv
// Purpose: Servo axes on the far side of the motion declaration block
// Assumes: All axes decelerate together on any stop request
// Notes: Servo starts on; nudge pushes an axis away while its servo is off
`timescale 1ns/100ps
module servo_axes_model
  import motion_decl_pkg::*;
#(parameter int DEC = 3)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [motion_decl_pkg::NA-1:0] run,
  input wire logic [motion_decl_pkg::NA-1:0] nudge,
  input wire logic stop,
  input wire logic [motion_decl_pkg::NA-1:0] servo_off_req,
  input wire logic [motion_decl_pkg::NA-1:0] servo_restore,
  input wire logic [motion_decl_pkg::NT-1:0] return_req,
  output logic [motion_decl_pkg::NA-1:0] axis_servo_on,
  output logic [motion_decl_pkg::NA-1:0] axis_moving,
  output logic [motion_decl_pkg::NA-1:0] axis_displaced,
  output logic [motion_decl_pkg::NT-1:0] return_done
);
  int cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      axis_servo_on <= '1;
      axis_moving <= '0;
      axis_displaced <= '0;
      return_done <= '0;
    end else begin
      // Deceleration lasts DEC+1 cycles
      cnt <= stop ? cnt + 1 : 0;
      axis_moving <= run & {NA{!(stop && cnt >= DEC)}};
      axis_servo_on <= (axis_servo_on & ~servo_off_req) | servo_restore;
      // Return to the stop point clears the displacement
      axis_displaced <= (|return_req) ? '0 : axis_displaced | (nudge & ~axis_servo_on);
      return_done <= return_req & ~return_done;
    end
  end
endmodule

// ===== tb/test_motion_decl.sv
// Purpose: Self-checking bench for the motion declaration block
// Assumes: APB master tasks, servo axes model on the far side
// Notes: Global flags drive pause and abort sources, except pin 5 for task 1's pause
`timescale 1ns/100ps
module test_motion_decl;
  import motion_decl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, son_req, son_tsk, dup_err, stop, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] din, gflag;
  logic [10:0] auto_arc;
  logic [NT-1:0] cmd_active, cmd_svoff, cmd_home, return_done, pause_req, abort_req, abort_done;
  logic [NT-1:0] return_req, resume, home_restart;
  logic [NA-1:0] axis_servo_on, axis_moving, axis_displaced, son_axes, servo_off_req, servo_restore, run, nudge;
  move_in_t move_in;
  move_out_t move_out;
  int errors, check_count, n_res, n_home, n_rest, n_adone, n_ret;
  motion_decl motion_decl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .din, .gflag, .cmd_active, .cmd_svoff, .cmd_home, .axis_servo_on, .axis_moving, .axis_displaced,
    .return_done, .son_req, .son_tsk, .son_axes, .move_in, .auto_arc, .move_out, .pause_req, .abort_req,
    .abort_done, .return_req, .resume, .home_restart, .servo_off_req, .servo_restore, .dup_err);
  assign stop = |{pause_req, abort_req};
  servo_axes_model servo_axes_model_i (.pclk, .presetn, .run, .nudge, .stop, .servo_off_req, .servo_restore,
    .return_req, .axis_servo_on, .axis_moving, .axis_displaced, .return_done);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    n_res += resume[0];
    n_home += home_restart[0];
    n_rest += |servo_restore;
    n_adone += abort_done[0];
    n_ret += return_done[0];
  end
  task automatic end_sim();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [7:0] ad(input int t, input logic [4:0] i);
    return 8'(t * 128) + {1'b0, i, 2'b00};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk("pslverr", {31'h0, e}, {31'h0, er});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("prdata", exp, rd);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic mv(input logic [3:0] ax, input logic [23:0] t, input logic tr, input logic [10:0] arc);
    @(posedge pclk);
    move_in.valid <= 1'b1;
    move_in.tgt <= {NA{24'h001000}};
    @(posedge pclk);
    move_in.valid <= 1'b0;
    @(negedge pclk);
    chk("move_valid", 32'h1, {31'h0, move_out.valid});
    chk("move_axes", {28'h0, ax}, {28'h0, move_out.axes});
    chk("move_trap", {31'h0, tr}, {31'h0, move_out.trap});
    chk("move_arc", {21'h0, arc}, {21'h0, move_out.arc});
    for (int i = 0; i < NA; i++) chk("move_tgt", {8'h0, ax[i] ? t : 24'h0}, {8'h0, move_out.tgt[i]});
  endtask
  initial begin
    #200000;
    errors++;
    end_sim();
  end
  initial begin
    {presetn, psel, penable, pwrite, son_req, son_tsk} = '0;
    {paddr, pwdata, din, gflag, auto_arc} = '0;
    {cmd_active, cmd_svoff, cmd_home, son_axes, run, nudge} = '0;
    move_in = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ad(0, R_SIG), 32'h0);
    rdc(ad(0, R_ARC), 32'h64);
    rdc(ad(0, R_BASE), 32'h1);
    rdc(ad(0, R_GRP), 32'hf);
    rdc(ad(0, R_HOLD), 32'h0);
    rdc(ad(0, R_ABRT), 32'h0);
    wr(ad(0, R_SIG), 32'd50, 1'b0);
    wr(ad(0, R_SIG), 32'd51, 1'b1);
    rdc(ad(0, R_SIG), 32'd50);
    rdc(ad(1, R_SIG), 32'h0);
    wr(ad(0, R_ARC), 32'd1200, 1'b0);
    wr(ad(0, R_ARC), 32'd1201, 1'b1);
    wr(ad(0, R_HOLD), 32'h71301, 1'b1);
    wr(ad(0, R_ABRT), 32'h61401, 1'b1);
    wr(ad(0, R_OFSRD), 32'h0, 1'b1);
    wr(ad(0, 5'h1f), 32'h0, 1'b1);
    // Axis 2 only, offset of minus five micrometres
    wr(ad(0, R_SIG), 32'h0, 1'b0);
    wr(ad(0, R_GRP), 32'h2, 1'b0);
    wr(ad(0, R_OFS), 32'h02fffffb, 1'b0);
    mv(4'b0010, 24'h000ffb, 1'b1, 11'd1200);
    wr(ad(0, R_BASE), 32'h2, 1'b0);
    wr(ad(0, R_SIG), 32'd30, 1'b0);
    mv(4'b0100, 24'h000ffb, 1'b0, 11'd1200);
    wr(ad(0, R_ARC), 32'h0, 1'b0);
    auto_arc <= 11'd2000;
    mv(4'b0100, 24'h000ffb, 1'b0, 11'h708);
    @(posedge pclk);
    auto_arc <= 11'd300;
    mv(4'b0100, 24'h000ffb, 1'b0, 11'd300);
    wr(ad(0, R_BASE), 32'h1, 1'b0);
    wr(ad(0, R_GRP), 32'h3, 1'b0);
    wr(ad(0, R_HOLD), 32'h41301, 1'b0);
    cmd_active <= 2'b11;
    cmd_svoff <= 2'b01;
    run <= 4'b0011;
    gflag[3] <= 1'b1;
    wt(4);
    chk("pause_req", 32'h0, {30'h0, pause_req});
    @(posedge pclk);
    cmd_svoff <= 2'b00;
    wt(4);
    chk("pause_req", 32'h1, {30'h0, pause_req});
    rdc(ad(0, R_STAT), 32'h1);
    gflag[3] <= 1'b0;
    wt(4);
    chk("pause_req", 32'h0, {30'h0, pause_req});
    chk("resumes", 32'h1, n_res);
    // Closed contact with servo off, then keep the type
    wr(ad(0, R_HOLD), 32'h61301, 1'b0);
    wr(ad(0, R_HOLD), 32'h01301, 1'b0);
    gflag[3] <= 1'b0;
    cmd_home <= 2'b01;
    wt(12);
    chk("servo_off_req", 32'h3, {28'h0, servo_off_req});
    rdc(ad(0, R_STAT), 32'h31);
    son_req <= 1'b1;
    son_tsk <= 1'b1;
    son_axes <= 4'b0001;
    nudge <= 4'b0001;
    @(posedge pclk);
    son_req <= 1'b0;
    wt(2);
    chk("dup_err", 32'h1, {31'h0, dup_err});
    @(posedge pclk);
    gflag[3] <= 1'b1;
    wt(14);
    chk("restores", 32'h1, n_rest);
    chk("returns", 32'h1, n_ret);
    chk("resumes", 32'h2, n_res);
    chk("home_restarts", 32'h1, n_home);
    wr(ad(0, R_CTRL), 32'h2, 1'b0);
    nudge <= 4'b0000;
    wt(1);
    chk("dup_err", 32'h0, {31'h0, dup_err});
    wr(ad(0, R_HOLD), 32'h0, 1'b0);
    gflag[3] <= 1'b0;
    wr(ad(0, R_ABRT), 32'h51401, 1'b0);
    wt(3);
    chk("abort_req", 32'h1, {30'h0, abort_req});
    chk("pause_req", 32'h0, {30'h0, pause_req});
    @(posedge pclk);
    cmd_active <= 2'b00;
    wt(10);
    chk("abort_dones", 32'h1, n_adone);
    chk("abort_req", 32'h0, {30'h0, abort_req});
    wr(ad(0, R_CTRL), 32'h1, 1'b0);
    rdc(ad(0, R_ABRT), 32'h0);
    rdc(ad(0, R_SIG), 32'h0);
    // Task 1 pauses on a synchronised pin, task 0 untouched
    wr(ad(1, R_HOLD), 32'h40501, 1'b0);
    cmd_active <= 2'b10;
    din[5] <= 1'b1;
    wt(5);
    chk("pause_req", 32'h2, {30'h0, pause_req});
    @(posedge pclk);
    din[5] <= 1'b0;
    wt(5);
    chk("pause_req", 32'h0, {30'h0, pause_req});
    end_sim();
  end
endmodule
